//--- rtl/adcrc_core_if.sv
// handshake between the control block and the successive-approximation core
`timescale 1ns/1ps
`default_nettype none
interface adcrc_core_if;
    logic start;
    logic [2:0] input_index;
    logic fast;
    logic first;
    logic abort;
    logic done;
    logic [9:0] value;
    modport ctrl (output start, output input_index, output fast, output first, output abort,
                  input done, input value);
    modport core (input start, input input_index, input fast, input first, input abort,
                  output done, output value);
endinterface : adcrc_core_if
`default_nettype wire

//--- rtl/adcrc_pkg.sv
// constants shared by the converter control block
package adcrc_pkg;
    localparam int unsigned adcrc_clk_hz = 20000000;
    // register byte offsets in the block's 4-bit window
    localparam logic [3:0] adcrc_off_res_a_hi = 4'h0;
    localparam logic [3:0] adcrc_off_res_a_lo = 4'h1;
    localparam logic [3:0] adcrc_off_res_b_hi = 4'h2;
    localparam logic [3:0] adcrc_off_res_b_lo = 4'h3;
    localparam logic [3:0] adcrc_off_res_c_hi = 4'h4;
    localparam logic [3:0] adcrc_off_res_c_lo = 4'h5;
    localparam logic [3:0] adcrc_off_res_d_hi = 4'h6;
    localparam logic [3:0] adcrc_off_res_d_lo = 4'h7;
    localparam logic [3:0] adcrc_off_ctrl_stat = 4'h8;
    localparam logic [3:0] adcrc_off_trig_ctrl = 4'h9;
    // reset values
    localparam logic [15:0] adcrc_result_reset = 16'h0000;
    localparam logic [7:0] adcrc_ctrl_stat_reset = 8'h00;
    localparam logic [7:0] adcrc_trig_ctrl_reset = 8'h7f;
    // control/status and trigger control field positions
    localparam int unsigned adcrc_bit_end_flag = 7;
    localparam int unsigned adcrc_bit_irq_en = 6;
    localparam int unsigned adcrc_bit_start = 5;
    localparam int unsigned adcrc_bit_scan = 4;
    localparam int unsigned adcrc_bit_speed = 3;
    localparam int unsigned adcrc_bit_trig_en = 7;
    // conversion lengths in states
    localparam int unsigned adcrc_first_slow_states = 266;
    localparam int unsigned adcrc_first_fast_states = 134;
    localparam int unsigned adcrc_next_slow_states = 256;
    localparam int unsigned adcrc_next_fast_states = 128;
    localparam int unsigned adcrc_cnt_w = 9;
endpackage : adcrc_pkg

//--- rtl/adcrc_sar_core.sv
// behavioural successive-approximation core: start pulse in, value and strobe out
`timescale 1ns/1ps
`default_nettype none
module adcrc_sar_core
    import adcrc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // analog side, digitised samples per input
    input wire logic [79:0] analog_in,
    // control side
    adcrc_core_if.core cif
);
    typedef struct packed {
        logic busy;
        logic [adcrc_cnt_w-1:0] cnt;
        logic [2:0] idx;
        logic done;
        logic [9:0] value;
    } adcrc_core_state_t;

    adcrc_core_state_t st;
    adcrc_core_state_t next_st;

    function automatic logic [adcrc_cnt_w-1:0] conv_len(input logic fast, input logic first);
        unique case ({first, fast})
            2'b10: conv_len = adcrc_cnt_w'(adcrc_first_slow_states);
            2'b11: conv_len = adcrc_cnt_w'(adcrc_first_fast_states);
            2'b01: conv_len = adcrc_cnt_w'(adcrc_next_fast_states);
            default: conv_len = adcrc_cnt_w'(adcrc_next_slow_states);
        endcase
    endfunction : conv_len

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (cif.abort) begin
            next_st.busy = 1'b0;
        end else if (cif.start) begin
            next_st.busy = 1'b1;
            next_st.idx = cif.input_index;
            // the strobe cycle itself counts as the final state
            next_st.cnt = conv_len(cif.fast, cif.first) - adcrc_cnt_w'(1); // [R16] [R19]
        end else if (st.busy) begin
            if (st.cnt == adcrc_cnt_w'(1)) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
                next_st.value = analog_in[st.idx*10 +: 10];
            end
            next_st.cnt = st.cnt - adcrc_cnt_w'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cif.done = st.done; // [R22]
    assign cif.value = st.value;
endmodule : adcrc_sar_core
`default_nettype wire

//--- rtl/adcrc_top.sv
// converter control and register front end on the 8-bit cpu bus
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] results sit left-justified in bits 15..6; bits 5..0 read zero.
// [R2] inputs 0/4 go to result A, 1/5 to B, 2/6 to C, 3/7 to D.
// [R3] all result registers clear on reset and in standby.
// [R4] upper-byte read returns high byte and latches low byte; low read returns latch.
// [R5] software reads the upper byte first; a lone low-byte read may be stale.
// [R6] control/status register clears to zero on reset and in standby.
// [R7] end flag sets at single conversion end or after whole scan group.
// [R8] end flag clears only by writing zero after reading it as one.
// [R9] interrupt enable bit gates end flag onto the interrupt request.
// [R10] start bit begins conversion, reads one while busy, self-clears in single mode.
// [R11] scan mode cycles inputs until start cleared, reset or standby.
// [R12] writing zero to start halts any running conversion.
// [R13] with trigger enable set, falling trigger edge sets the start bit.
// [R14] mode bit: zero single, one scan; resets to single.
// [R15] software clears start before changing mode, speed or input select.
// [R16] speed bit chooses 266 or 134 states for a conversion.
// [R17] input field picks one input, or group first through selected input in scan.
// [R18] trigger control resets to 0x7f; its lower seven bits read one.
// [R19] later scan conversions take 256 or 128 states by speed bit.
// [R20] every restart of a scan begins at the group's first input.
// [R21] writing one to the end flag does nothing.
// [R22] analog core takes start and index, returns 10-bit value and strobe.
module adcrc_top
    import adcrc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic standby,
    // cpu byte bus
    input wire logic bus_sel,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    // converter pins
    input wire logic ext_trigger_input_n,
    input wire logic [79:0] analog_in,
    // interrupt and status
    output logic conversion_end_irq,
    output logic conv_busy
);
    typedef struct packed {
        logic [9:0] res_a;
        logic [9:0] res_b;
        logic [9:0] res_c;
        logic [9:0] res_d;
        logic [7:0] low_latch;
        logic conversion_end_flag;
        logic end_irq_enable;
        logic conversion_start_bit;
        logic scan_mode;
        logic conversion_speed_select;
        logic [2:0] input_sel;
        logic ext_trigger_enable;
        logic flag_seen_one;
        logic trig_prev;
        logic busy;
        logic [2:0] cur_input;
        logic first_conv;
        logic core_start;
        logic core_abort;
        logic [7:0] rdata;
        logic irq;
    } adcrc_state_t;

    adcrc_state_t st;
    adcrc_state_t next_st;
    adcrc_core_if cif ();

    adcrc_sar_core u_core (
        .clk(clk),
        .rst_n(rst_n),
        .analog_in(analog_in),
        .cif(cif)
    );

    // 10-bit value placed in the 16-bit register view
    function automatic logic [15:0] result_word(input logic [9:0] v);
        result_word = {v, 6'h00}; // [R1]
    endfunction : result_word

    function automatic logic [9:0] pick_result(input adcrc_state_t s, input logic [1:0] slot);
        unique case (slot)
            2'h0: pick_result = s.res_a;
            2'h1: pick_result = s.res_b;
            2'h2: pick_result = s.res_c;
            default: pick_result = s.res_d;
        endcase
    endfunction : pick_result

    function automatic logic [7:0] ctrl_stat_view(input adcrc_state_t s);
        ctrl_stat_view = {s.conversion_end_flag, s.end_irq_enable, s.conversion_start_bit,
                          s.scan_mode, s.conversion_speed_select, s.input_sel};
    endfunction : ctrl_stat_view

    // first input of the group named by the top select bit
    function automatic logic [2:0] group_first(input logic [2:0] sel);
        group_first = {sel[2], 2'b00};
    endfunction : group_first

    logic rd_hit;
    logic wr_hit;
    logic [15:0] sel_word;
    logic [7:0] wr_val;
    logic trig_fall;
    logic start_req;
    logic stop_req;

    always_comb begin
        rd_hit = bus_sel && bus_rd;
        wr_hit = bus_sel && bus_wr;
        wr_val = bus_wdata;
        sel_word = result_word(pick_result(st, bus_addr[2:1]));
        trig_fall = st.trig_prev && !ext_trigger_input_n;
        next_st = st;
        next_st.core_start = 1'b0;
        next_st.core_abort = 1'b0;
        next_st.trig_prev = ext_trigger_input_n;
        start_req = 1'b0;
        stop_req = 1'b0;

        // register reads
        next_st.rdata = 8'h00;
        if (rd_hit) begin
            if (!bus_addr[3]) begin
                if (!bus_addr[0]) begin
                    next_st.rdata = sel_word[15:8]; // [R4]
                    next_st.low_latch = sel_word[7:0]; // [R4] [R5]
                end else begin
                    next_st.rdata = st.low_latch; // [R4]
                end
            end else if (bus_addr == adcrc_off_ctrl_stat) begin
                next_st.rdata = ctrl_stat_view(st);
                if (st.conversion_end_flag) begin
                    next_st.flag_seen_one = 1'b1; // [R8]
                end
            end else if (bus_addr == adcrc_off_trig_ctrl) begin
                next_st.rdata = {st.ext_trigger_enable, 7'h7f}; // [R18]
            end
        end

        // register writes
        if (wr_hit && bus_addr == adcrc_off_ctrl_stat) begin
            next_st.end_irq_enable = wr_val[adcrc_bit_irq_en];
            next_st.scan_mode = wr_val[adcrc_bit_scan]; // [R14]
            next_st.conversion_speed_select = wr_val[adcrc_bit_speed];
            next_st.input_sel = wr_val[2:0];
            if (!wr_val[adcrc_bit_end_flag] && st.flag_seen_one) begin
                next_st.conversion_end_flag = 1'b0; // [R8] [R21]
                next_st.flag_seen_one = 1'b0;
            end
            if (wr_val[adcrc_bit_start]) begin
                start_req = 1'b1; // [R10]
            end else begin
                stop_req = 1'b1; // [R12]
            end
        end
        if (wr_hit && bus_addr == adcrc_off_trig_ctrl) begin
            next_st.ext_trigger_enable = wr_val[adcrc_bit_trig_en];
        end
        if (st.ext_trigger_enable && trig_fall) begin
            start_req = 1'b1; // [R13]
        end

        // sequencing
        if (stop_req) begin
            next_st.conversion_start_bit = 1'b0; // [R12]
            next_st.busy = 1'b0;
            next_st.core_abort = st.busy;
        end else if (start_req && !st.busy) begin
            next_st.conversion_start_bit = 1'b1; // [R10]
            next_st.busy = 1'b1;
            next_st.first_conv = 1'b1;
            // scan always starts at group's first input
            next_st.cur_input = next_st.scan_mode ? group_first(next_st.input_sel) : next_st.input_sel; // [R17] [R20]
            next_st.core_start = 1'b1;
        end else if (st.busy && cif.done) begin
            unique case (st.cur_input[1:0]) // [R2]
                2'h0: next_st.res_a = cif.value;
                2'h1: next_st.res_b = cif.value;
                2'h2: next_st.res_c = cif.value;
                default: next_st.res_d = cif.value;
            endcase
            next_st.first_conv = 1'b0;
            if (!st.scan_mode) begin
                next_st.conversion_end_flag = 1'b1; // [R7]
                next_st.conversion_start_bit = 1'b0; // [R10]
                next_st.busy = 1'b0;
            end else begin
                if (st.cur_input[1:0] == st.input_sel[1:0]) begin
                    next_st.conversion_end_flag = 1'b1; // [R7]
                    next_st.cur_input = group_first(st.input_sel); // [R11]
                end else begin
                    next_st.cur_input = st.cur_input + 3'h1; // [R17]
                end
                next_st.core_start = 1'b1; // [R11]
            end
        end

        next_st.irq = next_st.conversion_end_flag && next_st.end_irq_enable; // [R9]

        if (standby) begin
            next_st = '0; // [R3] [R6]
            next_st.ext_trigger_enable = 1'b0; // [R18]
            next_st.trig_prev = 1'b1;
            next_st.core_abort = st.busy; // [R11]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0; // [R3] [R6] [R14]
            st.trig_prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign cif.start = st.core_start;
    assign cif.input_index = st.cur_input;
    assign cif.fast = st.conversion_speed_select; // [R16]
    assign cif.first = st.first_conv; // [R19]
    assign cif.abort = st.core_abort;

    assign bus_rdata = st.rdata;
    assign conversion_end_irq = st.irq;
    assign conv_busy = st.busy;
endmodule : adcrc_top
`default_nettype wire

//--- verification/adcrc_assertions.sv
// port-level checks of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcrc_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic standby,
    // cpu byte bus
    input wire logic bus_sel,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    // status
    input wire logic conversion_end_irq,
    input wire logic conv_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic rd_acc = bus_sel && bus_rd;
    wire logic wr_ctl = bus_sel && bus_wr && bus_addr == 4'h8 && !standby;
    AST_RESET: assert property (disable iff (1'b0) !rst_n |=> bus_rdata == 8'h00 && !conversion_end_irq && !conv_busy)
        else $error("outputs not cleared by reset");
    AST_STANDBY: assert property (standby |=> !conv_busy && !conversion_end_irq)
        else $error("standby left converter running");
    AST_IDLE_RDATA: assert property (!rd_acc |=> bus_rdata == 8'h00)
        else $error("read data without read");
    AST_LOW_ZERO: assert property (rd_acc && bus_addr[0] && !bus_addr[3] |=> bus_rdata[5:0] == 6'h00)
        else $error("result low bits not zero");
    AST_TRIG_ONES: assert property (rd_acc && !standby && bus_addr == 4'h9 |=> bus_rdata[6:0] == 7'h7f)
        else $error("trigger control low bits not one");
    AST_UNMAPPED: assert property (rd_acc && bus_addr > 4'h9 |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_START: assert property (wr_ctl && bus_wdata[5] && !conv_busy |=> conv_busy)
        else $error("start write did not start");
    AST_STOP: assert property (wr_ctl && !bus_wdata[5] |=> !conv_busy)
        else $error("stop write did not halt");
    AST_IRQ_OFF: assert property (wr_ctl && !bus_wdata[6] |-> ##2 !conversion_end_irq)
        else $error("irq raised while disabled");
endmodule : adcrc_chk
bind adcrc_top adcrc_chk adcrc_chk_i (.clk, .rst_n, .standby, .bus_sel, .bus_rd, .bus_wr, .bus_addr,
    .bus_wdata, .bus_rdata, .conversion_end_irq, .conv_busy);
`default_nettype wire

//--- verification/adcrc_cpu_model.sv
// cpu byte bus master model
`timescale 1ns/1ps
`default_nettype none
module adcrc_cpu_model (
    // clock
    input wire logic clk,
    // byte bus
    output logic bus_sel,
    output logic bus_rd,
    output logic bus_wr,
    output logic [3:0] bus_addr,
    output logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata
);
    initial begin
        {bus_sel, bus_rd, bus_wr, bus_addr, bus_wdata} = '0;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        {bus_sel, bus_wr, bus_addr, bus_wdata} = {2'b11, a, d};
        @(posedge clk) #1;
        {bus_sel, bus_wr, bus_wdata} = {2'b00, ~d};
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk) #1;
        {bus_sel, bus_rd, bus_addr} = {2'b11, a};
        @(posedge clk) #1;
        {bus_sel, bus_rd} = 2'b00;
        d = bus_rdata;
    endtask : rd
    // upper byte first, it loads the low-byte latch
    task automatic rd16(input logic [3:0] a, output logic [15:0] w);
        rd(a, w[15:8]);
        rd(a + 4'h1, w[7:0]);
    endtask : rd16
endmodule : adcrc_cpu_model
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import adcrc_pkg::*;
    logic clk, rst_n, standby, ext_trigger_input_n, bus_sel, bus_rd, bus_wr;
    logic conversion_end_irq, conv_busy;
    logic [79:0] analog_in;
    logic [3:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, d;
    logic [15:0] w;
    int bad_count, tests_run, n;
    adcrc_top adcrc_top_i (.clk, .rst_n, .standby, .bus_sel, .bus_rd, .bus_wr, .bus_addr, .bus_wdata,
        .bus_rdata, .ext_trigger_input_n, .analog_in, .conversion_end_irq, .conv_busy);
    adcrc_cpu_model adcrc_cpu_model_i (.clk, .bus_sel, .bus_rd, .bus_wr, .bus_addr, .bus_wdata,
        .bus_rdata);
    function automatic logic [9:0] smp(input int k);
        return 10'h155 + 10'(73 * k);
    endfunction : smp
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rdx(input logic [3:0] a, input logic [7:0] e);
        adcrc_cpu_model_i.rd(a, d);
        chk("rdata", {8'h00, d}, {8'h00, e});
    endtask : rdx
    task automatic res(input logic [3:0] a, input int k);
        adcrc_cpu_model_i.rd16(a, w);
        chk("result", w, {smp(k), 6'h00});
    endtask : res
    task automatic wait_idle();
        n = 0;
        while (conv_busy === 1'b1 && n < 2000) begin
            @(posedge clk) #1;
            n++;
        end
    endtask : wait_idle
    task automatic pulse_trig();
        ext_trigger_input_n = 1'b0;
        repeat (3) @(posedge clk) #1;
        ext_trigger_input_n = 1'b1;
    endtask : pulse_trig
    task automatic t_reset();
        for (int a = 0; a < 8; a++) rdx(4'(a), 8'h00);
        rdx(4'h8, 8'h00);
        rdx(4'h9, 8'h7f);
        rdx(4'ha, 8'h00);
        adcrc_cpu_model_i.wr(4'h9, 8'h00);
        rdx(4'h9, 8'h7f);
    endtask : t_reset
    task automatic t_single();
        adcrc_cpu_model_i.wr(4'h8, 8'h61);
        rdx(4'h8, 8'h61);
        wait_idle();
        chk("slow len", 16'(n >= 258 && n <= 270), 16'h1);
        chk("irq", 16'(conversion_end_irq), 16'h1);
        rdx(4'h8, 8'hc1);
        res(4'h2, 1);
        adcrc_cpu_model_i.wr(4'h8, 8'hc0);
        rdx(4'h8, 8'hc0);
        adcrc_cpu_model_i.wr(4'h8, 8'h00);
        rdx(4'h8, 8'h00);
        chk("irq", 16'(conversion_end_irq), 16'h0);
    endtask : t_single
    task automatic t_trig();
        adcrc_cpu_model_i.wr(4'h9, 8'h80);
        rdx(4'h9, 8'hff);
        adcrc_cpu_model_i.wr(4'h8, 8'h0c);
        pulse_trig();
        chk("trig busy", 16'(conv_busy), 16'h1);
        wait_idle();
        chk("fast len", 16'(n >= 120 && n <= 136), 16'h1);
        res(4'h0, 4);
        adcrc_cpu_model_i.wr(4'h9, 8'h00);
        // clear attempt before any read of the flag must be ignored
        adcrc_cpu_model_i.wr(4'h8, 8'h0c);
        rdx(4'h8, 8'h8c);
        chk("irq off", 16'(conversion_end_irq), 16'h0);
        pulse_trig();
        chk("trig off", 16'(conv_busy), 16'h0);
    endtask : t_trig
    task automatic t_scan();
        adcrc_cpu_model_i.wr(4'h8, 8'h3a);
        repeat (200) @(posedge clk) #1;
        rdx(4'h8, 8'h3a);
        // group end lands near 395 cycles only with 128-state later conversions
        repeat (195) @(posedge clk) #1;
        rdx(4'h8, 8'hba);
        chk("scan busy", 16'(conv_busy), 16'h1);
        res(4'h4, 2);
        adcrc_cpu_model_i.wr(4'h8, 8'h1a);
        chk("stop", 16'(conv_busy), 16'h0);
        analog_in[9:0] = smp(9);
        adcrc_cpu_model_i.wr(4'h8, 8'h3a);
        repeat (140) @(posedge clk) #1;
        res(4'h0, 9);
        standby = 1'b1;
        @(posedge clk) #1;
        standby = 1'b0;
        chk("standby", 16'(conv_busy), 16'h0);
        rdx(4'h8, 8'h00);
        rdx(4'h0, 8'h00);
        rdx(4'h9, 8'h7f);
    endtask : t_scan
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #500000;
        bad_count++;
        summarize();
    end
    initial begin
        {bad_count, tests_run, n} = '0;
        {rst_n, standby, ext_trigger_input_n} = 3'b001;
        for (int k = 0; k < 8; k++) analog_in[10*k +: 10] = smp(k);
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        t_reset();
        t_single();
        t_trig();
        t_scan();
        summarize();
    end
endmodule : tb_top
`default_nettype wire
